// ===== rtl/petc_consts.vh
// Constants for the pixel edge timing core
`ifndef PETC_CONSTS_VH
`define PETC_CONSTS_VH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define PETC_IDX_OPER      8'h00
`define PETC_IDX_FORMAT    8'h03
`define PETC_IDX_HCLK      8'h60
`define PETC_IDX_RGATE     8'h61
`define PETC_IDX_DRIVE     8'h62
`define PETC_IDX_SAMPLE    8'h63
`define PETC_IDX_PHASE     8'h64
`define PETC_IDX_STATUS    8'h65

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PETC_RST_OPER      12'h004
`define PETC_RST_FORMAT    6'h04
`define PETC_RST_HCLK      13'h1001
`define PETC_RST_RGATE     13'h0801
`define PETC_RST_DRIVE     15'h0000
`define PETC_RST_SAMPLE    12'h024
`define PETC_RST_PHASE     6'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PETC_EW_POL        0
`define PETC_EW_POS_LSB    1
`define PETC_EW_NEG_LSB    7
`define PETC_SS_RST_LSB    0
`define PETC_SS_DAT_LSB    6
`define PETC_DRV_FIELD_W   3
`define PETC_OP_PWR_LSB    0
`define PETC_OP_BLANK_BIT  5
`define PETC_FMT_TRI_BIT   3
`define PETC_FMT_BYP_BIT   4
`define PETC_FMT_GRAY_BIT  5

// ----------------------------------------
// Timing and codes
// ----------------------------------------
`define PETC_EDGE_COUNT    6'd48
`define PETC_EDGE_LAST     6'd47
`define PETC_QUAD_SPAN     4'hc
`define PETC_PWR_NORMAL    2'h0
`define PETC_PWR_STANDBY   2'h1
`define PETC_RESP_OKAY     2'h0
`define PETC_RESP_SLVERR   2'h2

`endif

// ===== rtl/petc_edge_decode.v
// Edge code to edge position decoder
`timescale 1ns/1ps
`default_nettype none
`include "petc_consts.vh"

module petc_edge_decode (
  // Code in
  input  wire [5:0] code,
  // Position out
  output wire [5:0] position,
  output wire       valid
);

  // ----------------------------------------
  // Quadrant base plus offset
  // ----------------------------------------
  wire [5:0] base;

  assign base     = {1'b0, code[5:4], 3'h0} + {2'h0, code[5:4], 2'h0};
  assign position = base + {2'h0, code[3:0]};
  assign valid    = (code[3:0] < `PETC_QUAD_SPAN);

endmodule
`default_nettype wire

// ===== rtl/petc_data_out.v
// Data output stage: blanking, coding, latch and three-state
`timescale 1ns/1ps
`default_nettype none
`include "petc_consts.vh"

module petc_data_out (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Controls
  input  wire        running,
  input  wire        latch_hit,
  input  wire        bypass,
  input  wire        gray,
  input  wire        tristate,
  input  wire        blank_level,
  // Data
  input  wire        blank_n,
  input  wire [11:0] sample_in,
  input  wire [11:0] clamp_level,
  output reg  [11:0] data_out,
  output reg         data_oe
);

  // ----------------------------------------
  // Value selection
  // ----------------------------------------
  wire [11:0] plain;
  wire [11:0] coded;

  assign plain = !blank_n ? (blank_level ? clamp_level : 12'h000) : sample_in;
  assign coded = gray ? (plain ^ {1'b0, plain[11:1]}) : plain;

  // ----------------------------------------
  // Output register
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_out <= 12'h000;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= !tristate;
      if (!running) begin
        data_out <= 12'h000;
      end else if (bypass || latch_hit) begin
        data_out <= coded;
      end
    end
  end

endmodule
`default_nettype wire

// ===== rtl/petc_core.v
// Pixel edge timing core with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "petc_consts.vh"

module petc_core (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Sensor clocks
  output wire        hclk_phase_a,
  output wire        hclk_phase_a_inv,
  output wire        hclk_phase_b,
  output wire        hclk_phase_b_inv,
  output wire        reset_gate_out,
  output wire [3:0]  hclk_oe,
  output wire        reset_gate_oe,
  // Sampling strobes
  output wire        reset_level_strobe,
  output wire        data_level_strobe,
  output wire        pixel_start,
  // Pixel data
  input  wire [11:0] adc_sample,
  input  wire [11:0] clamp_level,
  input  wire        pixel_blank_window_n,
  output wire [11:0] data_out,
  output wire        data_oe,
  // Power state
  output wire        ref_standby,
  output wire        power_down
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg  [11:0] operation_control_reg;
  reg  [5:0]  output_format_control_reg;
  reg  [12:0] hclock_edge_word_reg;
  reg  [12:0] reset_gate_edge_word_reg;
  reg  [14:0] driver_strength_word_reg;
  reg  [11:0] sample_strobe_word_reg;
  reg  [5:0]  output_phase_field_reg;

  // ----------------------------------------
  // Bus state
  // ----------------------------------------
  reg         awready_reg;
  reg         wready_reg;
  reg         bvalid_reg;
  reg  [1:0]  bresp_reg;
  reg         arready_reg;
  reg         rvalid_reg;
  reg  [1:0]  rresp_reg;
  reg  [31:0] rdata_reg;
  reg         aw_full_reg;
  reg         w_full_reg;
  reg  [9:0]  waddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;

  // ----------------------------------------
  // Timing state
  // ----------------------------------------
  reg  [5:0]  edge_pos_reg;
  reg         hclk_level_reg;
  reg         rgate_level_reg;
  reg         hclk_a_reg;
  reg         hclk_a_inv_reg;
  reg         hclk_b_reg;
  reg         hclk_b_inv_reg;
  reg         rgate_reg;
  reg  [3:0]  hclk_oe_reg;
  reg         rgate_oe_reg;
  reg         rstrobe_reg;
  reg         dstrobe_reg;
  reg         pstart_reg;
  reg         standby_reg;
  reg         pdown_reg;

  wire        aw_hs;
  wire        w_hs;
  wire        ar_hs;
  wire        do_write;
  wire [31:0] wmask;
  wire [31:0] wmerge_src;
  reg  [31:0] rd_value;
  reg         rd_hit;
  reg         wr_hit;

  wire [1:0]  power_state_field;
  wire        running;
  wire [41:0] codes;
  wire [6:0]  hit;
  wire        hclk_level_next;
  wire        rgate_level_next;
  wire        hclk_pol;
  wire        rgate_pol;

  assign aw_hs    = s_axi_awvalid && awready_reg;
  assign w_hs     = s_axi_wvalid && wready_reg;
  assign ar_hs    = s_axi_arvalid && arready_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  // ----------------------------------------
  // Byte-lane mask
  // ----------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_mask
      assign wmask[8*gb+7:8*gb] = {8{wstrb_reg[gb]}};
    end
  endgenerate

  assign wmerge_src = wdata_reg & wmask;

  // ----------------------------------------
  // Write address decode
  // ----------------------------------------
  always @* begin
    wr_hit = 1'b1;
    case (waddr_reg)
      {2'h0, `PETC_IDX_OPER},
      {2'h0, `PETC_IDX_FORMAT},
      {2'h0, `PETC_IDX_HCLK},
      {2'h0, `PETC_IDX_RGATE},
      {2'h0, `PETC_IDX_DRIVE},
      {2'h0, `PETC_IDX_SAMPLE},
      {2'h0, `PETC_IDX_PHASE},
      {2'h0, `PETC_IDX_STATUS}: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Write channels and register updates
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg               <= 1'b1;
      wready_reg                <= 1'b1;
      bvalid_reg                <= 1'b0;
      bresp_reg                 <= `PETC_RESP_OKAY;
      aw_full_reg               <= 1'b0;
      w_full_reg                <= 1'b0;
      waddr_reg                 <= 10'h000;
      wdata_reg                 <= 32'h0000_0000;
      wstrb_reg                 <= 4'h0;
      operation_control_reg     <= `PETC_RST_OPER;
      output_format_control_reg <= `PETC_RST_FORMAT;
      hclock_edge_word_reg      <= `PETC_RST_HCLK;
      reset_gate_edge_word_reg  <= `PETC_RST_RGATE;
      driver_strength_word_reg  <= `PETC_RST_DRIVE;
      sample_strobe_word_reg    <= `PETC_RST_SAMPLE;
      output_phase_field_reg    <= `PETC_RST_PHASE;
    end else begin
      if (aw_hs) begin
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
        waddr_reg   <= s_axi_awaddr[11:2];
      end
      if (w_hs) begin
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? `PETC_RESP_OKAY : `PETC_RESP_SLVERR;
        case (waddr_reg)
          {2'h0, `PETC_IDX_OPER}:
            operation_control_reg <= (operation_control_reg & ~wmask[11:0]) | wmerge_src[11:0];
          {2'h0, `PETC_IDX_FORMAT}:
            output_format_control_reg <= (output_format_control_reg & ~wmask[5:0]) | wmerge_src[5:0];
          {2'h0, `PETC_IDX_HCLK}:
            hclock_edge_word_reg <= (hclock_edge_word_reg & ~wmask[12:0]) | wmerge_src[12:0];
          {2'h0, `PETC_IDX_RGATE}:
            reset_gate_edge_word_reg <= (reset_gate_edge_word_reg & ~wmask[12:0]) | wmerge_src[12:0];
          {2'h0, `PETC_IDX_DRIVE}:
            driver_strength_word_reg <= (driver_strength_word_reg & ~wmask[14:0]) | wmerge_src[14:0];
          {2'h0, `PETC_IDX_SAMPLE}:
            sample_strobe_word_reg <= (sample_strobe_word_reg & ~wmask[11:0]) | wmerge_src[11:0];
          {2'h0, `PETC_IDX_PHASE}:
            output_phase_field_reg <= (output_phase_field_reg & ~wmask[5:0]) | wmerge_src[5:0];
          default: begin
          end
        endcase
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  always @* begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    case (s_axi_araddr[11:2])
      {2'h0, `PETC_IDX_OPER}:   rd_value = {20'h00000, operation_control_reg};
      {2'h0, `PETC_IDX_FORMAT}: rd_value = {26'h0000000, output_format_control_reg};
      {2'h0, `PETC_IDX_HCLK}:   rd_value = {19'h00000, hclock_edge_word_reg};
      {2'h0, `PETC_IDX_RGATE}:  rd_value = {19'h00000, reset_gate_edge_word_reg};
      {2'h0, `PETC_IDX_DRIVE}:  rd_value = {17'h00000, driver_strength_word_reg};
      {2'h0, `PETC_IDX_SAMPLE}: rd_value = {20'h00000, sample_strobe_word_reg};
      {2'h0, `PETC_IDX_PHASE}:  rd_value = {26'h0000000, output_phase_field_reg};
      {2'h0, `PETC_IDX_STATUS}:
        rd_value = {20'h00000, pdown_reg, standby_reg, rgate_level_reg, hclk_level_reg, 2'h0, edge_pos_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Read channels
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `PETC_RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      if (ar_hs) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= rd_value;
        rresp_reg   <= rd_hit ? `PETC_RESP_OKAY : `PETC_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Edge position counter
  // ----------------------------------------
  assign power_state_field = operation_control_reg[`PETC_OP_PWR_LSB+1:`PETC_OP_PWR_LSB];
  assign running           = !power_state_field[1];

  always @(posedge aclk) begin
    if (!aresetn) begin
      edge_pos_reg <= 6'h00;
    end else if (!running || edge_pos_reg == `PETC_EDGE_LAST) begin
      edge_pos_reg <= 6'h00;
    end else begin
      edge_pos_reg <= edge_pos_reg + 6'h01;
    end
  end

  // ----------------------------------------
  // Edge code decoders
  // ----------------------------------------
  assign codes = {output_phase_field_reg,
                  sample_strobe_word_reg[`PETC_SS_DAT_LSB+5:`PETC_SS_DAT_LSB],
                  sample_strobe_word_reg[`PETC_SS_RST_LSB+5:`PETC_SS_RST_LSB],
                  reset_gate_edge_word_reg[`PETC_EW_NEG_LSB+5:`PETC_EW_NEG_LSB],
                  reset_gate_edge_word_reg[`PETC_EW_POS_LSB+5:`PETC_EW_POS_LSB],
                  hclock_edge_word_reg[`PETC_EW_NEG_LSB+5:`PETC_EW_NEG_LSB],
                  hclock_edge_word_reg[`PETC_EW_POS_LSB+5:`PETC_EW_POS_LSB]};

  genvar ge;
  generate
    for (ge = 0; ge < 7; ge = ge + 1) begin : g_edge
      wire [5:0] epos;
      wire       evalid;
      petc_edge_decode u_dec (
        .code     (codes[6*ge+5:6*ge]),
        .position (epos),
        .valid    (evalid)
      );
      assign hit[ge] = running && evalid && (epos == edge_pos_reg);
    end
  endgenerate

  // ----------------------------------------
  // Clock waveform levels
  // ----------------------------------------
  assign hclk_level_next  = hit[1] ? 1'b0 : (hit[0] ? 1'b1 : hclk_level_reg);
  assign rgate_level_next = hit[3] ? 1'b0 : (hit[2] ? 1'b1 : rgate_level_reg);
  assign hclk_pol         = hclock_edge_word_reg[`PETC_EW_POL];
  assign rgate_pol        = reset_gate_edge_word_reg[`PETC_EW_POL];

  always @(posedge aclk) begin
    if (!aresetn) begin
      hclk_level_reg  <= 1'b0;
      rgate_level_reg <= 1'b0;
      hclk_a_reg      <= 1'b0;
      hclk_a_inv_reg  <= 1'b1;
      hclk_b_reg      <= 1'b0;
      hclk_b_inv_reg  <= 1'b1;
      rgate_reg       <= 1'b0;
      hclk_oe_reg     <= 4'h0;
      rgate_oe_reg    <= 1'b0;
      rstrobe_reg     <= 1'b0;
      dstrobe_reg     <= 1'b0;
      pstart_reg      <= 1'b0;
      standby_reg     <= 1'b0;
      pdown_reg       <= 1'b0;
    end else begin
      hclk_level_reg  <= running && hclk_level_next;
      rgate_level_reg <= running && rgate_level_next;
      hclk_a_reg      <= running && (hclk_pol ? hclk_level_next : !hclk_level_next);
      hclk_b_reg      <= running && (hclk_pol ? hclk_level_next : !hclk_level_next);
      hclk_a_inv_reg  <= !(running && (hclk_pol ? hclk_level_next : !hclk_level_next));
      hclk_b_inv_reg  <= !(running && (hclk_pol ? hclk_level_next : !hclk_level_next));
      rgate_reg       <= running && (rgate_pol ? rgate_level_next : !rgate_level_next);
      hclk_oe_reg[0]  <= running && (driver_strength_word_reg[2:0] != 3'h0);
      hclk_oe_reg[1]  <= running && (driver_strength_word_reg[5:3] != 3'h0);
      hclk_oe_reg[2]  <= running && (driver_strength_word_reg[8:6] != 3'h0);
      hclk_oe_reg[3]  <= running && (driver_strength_word_reg[11:9] != 3'h0);
      rgate_oe_reg    <= running && (driver_strength_word_reg[14:12] != 3'h0);
      rstrobe_reg     <= hit[4];
      dstrobe_reg     <= hit[5];
      pstart_reg      <= running && (edge_pos_reg == 6'h00);
      standby_reg     <= (power_state_field == `PETC_PWR_STANDBY);
      pdown_reg       <= !running;
    end
  end

  // ----------------------------------------
  // Data output stage
  // ----------------------------------------
  petc_data_out u_dout (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .running     (running),
    .latch_hit   (hit[6]),
    .bypass      (output_format_control_reg[`PETC_FMT_BYP_BIT]),
    .gray        (output_format_control_reg[`PETC_FMT_GRAY_BIT]),
    .tristate    (output_format_control_reg[`PETC_FMT_TRI_BIT] || !running),
    .blank_level (operation_control_reg[`PETC_OP_BLANK_BIT]),
    .blank_n     (pixel_blank_window_n),
    .sample_in   (adc_sample),
    .clamp_level (clamp_level),
    .data_out    (data_out),
    .data_oe     (data_oe)
  );

  // ----------------------------------------
  // Output wiring
  // ----------------------------------------
  assign s_axi_awready      = awready_reg;
  assign s_axi_wready       = wready_reg;
  assign s_axi_bvalid       = bvalid_reg;
  assign s_axi_bresp        = bresp_reg;
  assign s_axi_arready      = arready_reg;
  assign s_axi_rvalid       = rvalid_reg;
  assign s_axi_rresp        = rresp_reg;
  assign s_axi_rdata        = rdata_reg;
  assign hclk_phase_a       = hclk_a_reg;
  assign hclk_phase_a_inv   = hclk_a_inv_reg;
  assign hclk_phase_b       = hclk_b_reg;
  assign hclk_phase_b_inv   = hclk_b_inv_reg;
  assign reset_gate_out     = rgate_reg;
  assign hclk_oe            = hclk_oe_reg;
  assign reset_gate_oe      = rgate_oe_reg;
  assign reset_level_strobe = rstrobe_reg;
  assign data_level_strobe  = dstrobe_reg;
  assign pixel_start        = pstart_reg;
  assign ref_standby        = standby_reg;
  assign power_down         = pdown_reg;

endmodule
`default_nettype wire

// ===== verif/petc_core_monitor.sv
// Assertion checker for the pixel edge timing core
`timescale 1ns/1ps
`default_nettype none
module petc_core_monitor (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Timing and data outputs
  input wire logic        hclk_phase_a,
  input wire logic        hclk_phase_a_inv,
  input wire logic        hclk_phase_b,
  input wire logic        hclk_phase_b_inv,
  input wire logic        reset_gate_out,
  input wire logic [3:0]  hclk_oe,
  input wire logic        reset_level_strobe,
  input wire logic        pixel_start,
  input wire logic [11:0] data_out,
  input wire logic        data_oe,
  input wire logic        ref_standby,
  input wire logic        power_down
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_ainv; hclk_phase_a_inv != hclk_phase_a; endproperty
  a_ainv: assert property (p_ainv) else $error("phase a inverse wrong");
  property p_binv; hclk_phase_b_inv != hclk_phase_b; endproperty
  a_binv: assert property (p_binv) else $error("phase b inverse wrong");
  property p_shared; hclk_phase_b == hclk_phase_a; endproperty
  a_shared: assert property (p_shared) else $error("phase b differs from a");
  property p_period; pixel_start && !power_down && !$past(power_down) |-> ##48 (pixel_start || power_down); endproperty
  a_period: assert property (p_period) else $error("pixel period not 48");
  property p_strobe; reset_level_strobe && !power_down |=> !reset_level_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe longer than one cycle");
  property p_pdoff; power_down && $past(power_down) |-> !data_oe && hclk_oe == 4'h0 && data_out == 12'h000; endproperty
  a_pdoff: assert property (p_pdoff) else $error("outputs live in power-down");
  property p_pdclk; power_down && $past(power_down) |-> !hclk_phase_a && !reset_gate_out; endproperty
  a_pdclk: assert property (p_pdclk) else $error("clocks run in power-down");
  property p_excl; !(ref_standby && power_down); endproperty
  a_excl: assert property (p_excl) else $error("standby and power-down together");
endmodule
bind petc_core petc_core_monitor i_petc_core_monitor (.aclk(aclk), .aresetn(aresetn), .hclk_phase_a(hclk_phase_a),
  .hclk_phase_a_inv(hclk_phase_a_inv), .hclk_phase_b(hclk_phase_b), .hclk_phase_b_inv(hclk_phase_b_inv),
  .reset_gate_out(reset_gate_out), .hclk_oe(hclk_oe), .reset_level_strobe(reset_level_strobe),
  .pixel_start(pixel_start), .data_out(data_out), .data_oe(data_oe), .ref_standby(ref_standby),
  .power_down(power_down));
`default_nettype wire

// ===== verif/petc_sensor_model.sv
// Sensor model: one new pixel value every master clock cycle
`timescale 1ns/1ps
`default_nettype none
module petc_sensor_model (
  // Clock
  input  wire logic        aclk,
  // Pixel value
  output var  logic [11:0] adc_sample
);
  initial adc_sample = 12'h000;
  always @(posedge aclk) adc_sample <= adc_sample + 12'h29b;
endmodule
`default_nettype wire

// ===== verif/pixel_edge_timing_core_tb.sv
// Testbench for the pixel edge timing core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pixel_edge_timing_core_tb;
  logic        aclk, aresetn, awv, wv, bready, arv, rready, blank_n, awr, wr_r, bv, arr, rv;
  logic        ha, hai, hb, hbi, rg, rgoe, rls, dls, pst, doe, stby, pd;
  logic [11:0] awaddr, araddr, clamp, adc, dout;
  logic [31:0] wdata, rdata, seed;
  logic [1:0]  bresp, rresp;
  logic [3:0]  hoe;
  logic [33:0] bq[$], be;
  logic [23:0] tq[$], te;
  logic [5:0]  ca, cr, orl, odl, ix, v, lp;
  logic        lat_on, lat_ok;
  logic [11:0] lat_v;
  int          n_errors, total_checks, k;
  petc_core i_petc_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .hclk_phase_a(ha), .hclk_phase_a_inv(hai), .hclk_phase_b(hb),
    .hclk_phase_b_inv(hbi), .reset_gate_out(rg), .hclk_oe(hoe), .reset_gate_oe(rgoe), .reset_level_strobe(rls),
    .data_level_strobe(dls), .pixel_start(pst), .adc_sample(adc), .clamp_level(clamp),
    .pixel_blank_window_n(blank_n), .data_out(dout), .data_oe(doe), .ref_standby(stby), .power_down(pd));
  petc_sensor_model i_petc_sensor_model (.aclk(aclk), .adc_sample(adc));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    bq.push_back(e);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
  endtask
  task automatic note_period(input logic [23:0] e);
    @(posedge aclk iff pst);
    repeat (2) @(posedge aclk);
    tq.push_back(e);
    @(posedge aclk iff pst);
    @(posedge aclk);
  endtask
  // Bus answers and per-period edge measurements against the noted results
  always @(posedge aclk) begin
    if (bv && bready) begin
      be = bq.pop_front();
      `CHK({bresp, 32'h0}, be)
    end
    if (rv && rready) begin
      be = bq.pop_front();
      `CHK({rresp, rdata}, be)
    end
    ix = pst ? 6'd0 : ix + 6'd1;
    if (pst) begin
      if (tq.size() > 0) begin
        te = tq.pop_front();
        `CHK({ca, cr, orl, odl}, te)
      end
      ca = 6'd0;
      cr = 6'd0;
    end
    ca = ca + {5'h0, ha};
    cr = cr + {5'h0, rg};
    if (rls) orl = ix;
    if (dls) odl = ix;
    if (!lat_on) lat_ok = 1'b0;
    else begin
      if (lat_ok) `CHK(dout, lat_v)
      if (ix == lp) begin
        lat_v = adc;
        lat_ok = 1'b1;
      end
    end
  end
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (6000) @(posedge aclk);
    n_errors++;
    print_verdict();
  end
  initial begin
    {aresetn, awv, wv, bready, arv, rready, awaddr, araddr, wdata, clamp, lat_on} = '0;
    blank_n = 1'b1;
    seed = 32'hc5a4;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h000, 34'h4);
    rd(12'h00c, 34'h4);
    rd(12'h180, 34'h1001);
    rd(12'h184, 34'h801);
    rd(12'h188, 34'h0);
    rd(12'h18c, 34'h24);
    rd(12'h190, 34'h0);
    rd(12'h1fc, {2'h2, 32'h0});
    wr(12'h1f8, 32'h1, 2'h2);
    note_period({6'd24, 6'd12, 6'd28, 6'd0});
    wr(12'h180, 32'h1a0b, 2'h0);
    wr(12'h184, 32'h1ccd, 2'h0);
    wr(12'h18c, 32'h43b, 2'h0);
    note_period({6'd35, 6'd15, 6'd47, 6'd12});
    wr(12'h180, 32'h1a0a, 2'h0);
    note_period({6'd13, 6'd15, 6'd47, 6'd12});
    wr(12'h188, 32'h7688, 2'h0);
    repeat (3) @(posedge aclk);
    `CHK({hoe, rgoe}, 5'h1d)
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      v = {seed[5:4], seed[3:0] % 4'hc};
      wr(12'h190, {26'h0, v}, 2'h0);
      rd(12'h190, {28'h0, v});
    end
    wr(12'h00c, 32'h04, 2'h0);
    lp <= 6'((v[5:4] * 12 + v[3:0] + 47) % 48);
    lat_on <= 1'b1;
    repeat (150) @(posedge aclk);
    lat_on <= 1'b0;
    seed = xs(seed);
    clamp <= seed[11:0];
    blank_n <= 1'b0;
    wr(12'h00c, 32'h14, 2'h0);
    wr(12'h000, 32'h24, 2'h0);
    repeat (60) @(posedge aclk);
    `CHK({doe, dout}, {1'b1, clamp})
    wr(12'h000, 32'h04, 2'h0);
    repeat (60) @(posedge aclk);
    `CHK(dout, 12'h000)
    wr(12'h000, 32'h24, 2'h0);
    wr(12'h00c, 32'h34, 2'h0);
    repeat (60) @(posedge aclk);
    `CHK(dout, clamp ^ (clamp >> 1))
    wr(12'h00c, 32'h3c, 2'h0);
    repeat (60) @(posedge aclk);
    `CHK(doe, 1'b0)
    wr(12'h000, 32'h25, 2'h0);
    repeat (4) @(posedge aclk);
    `CHK({stby, pd}, 2'b10)
    wr(12'h000, 32'h26, 2'h0);
    repeat (4) @(posedge aclk);
    `CHK({stby, pd, doe}, 3'b010)
    print_verdict();
  end
endmodule
`default_nettype wire
